// file: ee_slave.sv
// Behaviour
// - SDA fall with SCL high starts transfer
// - SDA rise with SCL high is stop
// - stop during read returns to standby
// - stop during write starts programming
// - data changes only while SCL low
// - eight bits then receiver acks ninth
// - header: type code, select bits, direction
// - ack header only when select pins match
// - byte write: header, two address, data
// - page write accepts up to 128 bytes
// - page write: only low 7 address bits increment
// - program exactly the received page bytes
// - write protect high blocks array writes
// - no ack on data while protected
// - busy programming: ignore bus, no ack
// - read header sends byte at counter
// - random read: dummy write then read
// - master ack fetches next address byte
// - read counter wraps across whole array
// - start then stop resets to idle
module ee_slave #(
    parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary value
    parameter int WRITE_CYCLES = ee_pkg::WRITE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_protect,
    output logic write_busy
);
    localparam int TW = ee_pkg::TMR_W;
    localparam logic [TW-1:0] WR_LIM = TW'(WRITE_CYCLES);
    localparam logic [TW-1:0] TMR_ONE = TW'(1);
    localparam int PB = ee_pkg::PAGE_BYTES;
    localparam int HW = ee_pkg::HI_W;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] wp_s;
        logic [1:0][2:0] sel_s;
        ee_pkg::ee_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [1:0] idx;
        logic rw;
        logic [7:0] addr_hi;
        logic [15:0] addr;
        logic drive;
        logic mack;
        logic [PB-1:0][7:0] page_data;
        logic [PB-1:0] page_vld;
        logic wr_seen;
        logic prog;
        logic [ee_pkg::PAGE_W-1:0] scan;
        logic scan_done;
        logic [TW-1:0] tmr;
    } ee_slave_t;

    ee_slave_t q, d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic scl_hi, rise, fall, start, stop, byte_end;
    logic [7:0] rd_data;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, mem_ready;
    logic [ee_pkg::FIFO_W-1:0] fifo_in_data, fifo_out_data;

    // =========================================================
    // reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // =========================================================
    // line events
    assign scl_hi = q.scl_s[1] & q.scl_s[2];
    assign rise = q.scl_s[1] & ~q.scl_s[2];
    assign fall = ~q.scl_s[1] & q.scl_s[2];
    assign start = scl_hi & q.sda_s[2] & ~q.sda_s[1];
    assign stop = scl_hi & ~q.sda_s[2] & q.sda_s[1];
    assign byte_end = fall & (q.st == ee_pkg::EE_RX)
        & (q.bit_cnt == ee_pkg::BYTE_BITS);

    assign sda_o = 1'b0;
    assign sda_oe = q.drive;
    assign write_busy = q.prog;

    // =========================================================
    // program path
    assign fifo_in_valid = q.prog & ~q.scan_done & q.page_vld[q.scan];
    assign fifo_in_data = {q.addr[15:ee_pkg::PAGE_W], q.scan,
        q.page_data[q.scan]};

    ee_fifo #(
        .WIDTH(ee_pkg::FIFO_W),
        .DEPTH(ee_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(mem_ready),
        .out_data(fifo_out_data)
    );

    ee_array #(
        .AW(ee_pkg::ADDR_W),
        .DW(ee_pkg::DATA_W),
        .PROG(ee_pkg::PROG_CYCLES)
    ) u_array (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_valid(fifo_out_valid),
        .wr_ready(mem_ready),
        .wr_word(fifo_out_data),
        .rd_addr(q.addr),
        .rd_data(rd_data)
    );

    // =========================================================
    // sequencer
    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        d.wp_s = {q.wp_s[0], write_protect};
        d.sel_s = {q.sel_s[0],
            {select_pin_bit2, select_pin_bit1, select_pin_bit0}};

        // scan page buffer into program queue
        if (q.prog && !q.scan_done) begin
            if (!q.page_vld[q.scan] || fifo_in_ready) begin
                d.scan = q.scan + ee_pkg::PAGE_ONE;
                d.scan_done = q.scan == ee_pkg::PAGE_LAST;
            end
        end
        if (q.prog && q.tmr != WR_LIM) begin
            d.tmr = q.tmr + TMR_ONE;
        end
        if (q.prog && q.tmr == WR_LIM && q.scan_done && !fifo_out_valid
            && mem_ready) begin
            d.prog = 1'b0;
            d.page_vld = '0;
        end

        if (start) begin
            d.st = ee_pkg::EE_RX;
            d.bit_cnt = ee_pkg::BIT_ZERO;
            d.idx = ee_pkg::IDX_DEV;
            d.drive = 1'b0;
            d.wr_seen = 1'b0;
            if (!q.prog) begin
                d.page_vld = '0;
            end
        end else if (stop) begin
            // read or idle ends in standby
            d.st = ee_pkg::EE_IDLE;
            d.drive = 1'b0;
            d.wr_seen = 1'b0;
            if (q.wr_seen && !q.prog) begin
                d.prog = 1'b1;
                d.tmr = '0;
                d.scan = '0;
                d.scan_done = 1'b0;
            end
        end else begin
            unique case (q.st)
                ee_pkg::EE_IDLE: begin
                end
                ee_pkg::EE_RX: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], q.sda_s[1]};
                        d.bit_cnt = q.bit_cnt + ee_pkg::BIT_ONE;
                    end else if (byte_end) begin
                        d.bit_cnt = ee_pkg::BIT_ZERO;
                        d.st = ee_pkg::EE_ACK;
                        d.drive = 1'b1;
                        if (q.idx != ee_pkg::IDX_DATA) begin
                            d.idx = q.idx + 2'h1;
                        end
                        unique case (q.idx)
                            ee_pkg::IDX_DEV: begin
                                d.rw = q.sh[0];
                                if (q.sh[7:4] != DEV_CODE
                                    || q.sh[3:1] != q.sel_s[1]
                                    || q.prog) begin
                                    d.st = ee_pkg::EE_IDLE;
                                    d.drive = 1'b0;
                                end
                            end
                            ee_pkg::IDX_AHI: begin
                                d.addr_hi = q.sh;
                            end
                            ee_pkg::IDX_ALO: begin
                                d.addr = {q.addr_hi, q.sh};
                            end
                            ee_pkg::IDX_DATA: begin
                                if (q.wp_s[1]) begin
                                    d.drive = 1'b0;
                                end else begin
                                    d.page_data[q.addr[6:0]] = q.sh;
                                    d.page_vld[q.addr[6:0]] = 1'b1;
                                    d.wr_seen = 1'b1;
                                    d.addr[6:0] = q.addr[6:0]
                                        + ee_pkg::PAGE_ONE;
                                end
                            end
                        endcase
                    end
                end
                ee_pkg::EE_ACK: begin
                    if (fall) begin
                        d.drive = 1'b0;
                        d.st = ee_pkg::EE_RX;
                        if (q.rw && q.idx == ee_pkg::IDX_AHI) begin
                            d.st = ee_pkg::EE_TX;
                            d.sh = rd_data;
                            d.drive = ~rd_data[7];
                        end
                    end
                end
                ee_pkg::EE_TX: begin
                    if (rise) begin
                        d.bit_cnt = q.bit_cnt + ee_pkg::BIT_ONE;
                    end else if (fall) begin
                        if (q.bit_cnt == ee_pkg::BYTE_BITS) begin
                            d.bit_cnt = ee_pkg::BIT_ZERO;
                            d.drive = 1'b0;
                            d.st = ee_pkg::EE_MACK;
                            d.addr = q.addr + ee_pkg::ADDR_ONE;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.drive = ~q.sh[6];
                        end
                    end
                end
                ee_pkg::EE_MACK: begin
                    if (rise) begin
                        d.mack = ~q.sda_s[1];
                    end else if (fall) begin
                        if (q.mack) begin
                            d.st = ee_pkg::EE_TX;
                            d.sh = rd_data;
                            d.drive = ~rd_data[7];
                        end else begin
                            d.st = ee_pkg::EE_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // =========================================================
    // checks
    a_start_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start |=> q.st == ee_pkg::EE_RX && q.bit_cnt == ee_pkg::BIT_ZERO
        && !sda_oe) else $error("start did not open a frame");
    a_stop_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop |=> q.st == ee_pkg::EE_IDLE && !sda_oe)
        else $error("stop did not idle");
    a_read_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop && (q.st == ee_pkg::EE_TX || q.st == ee_pkg::EE_MACK)
        |=> q.st == ee_pkg::EE_IDLE && $stable(q.prog))
        else $error("read not aborted by stop");
    a_write_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop && q.wr_seen && !q.prog |=> write_busy && q.tmr == '0)
        else $error("write cycle not started");
    a_busy_nack: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_end && q.idx == ee_pkg::IDX_DEV && q.prog && !start && !stop
        |=> q.st == ee_pkg::EE_IDLE && !sda_oe)
        else $error("header acked while busy");
    a_wp_nack: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_end && q.idx == ee_pkg::IDX_DATA && q.wp_s[1] && !start && !stop
        |=> q.st == ee_pkg::EE_ACK && !sda_oe && $stable(q.page_vld))
        else $error("protected byte acked or stored");
    a_page_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_end && q.idx == ee_pkg::IDX_DATA && !q.wp_s[1] && !start && !stop
        |=> q.addr[15:7] == $past(q.addr[15:7])
        && q.addr[6:0] == $past(q.addr[6:0]) + ee_pkg::PAGE_ONE)
        else $error("page address step wrong");
    a_read_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        q.st == ee_pkg::EE_TX && fall && q.bit_cnt == ee_pkg::BYTE_BITS
        && !start && !stop |=> q.addr == $past(q.addr) + ee_pkg::ADDR_ONE
        ##0 q.st == ee_pkg::EE_MACK) else $error("read counter step");
    a_ack_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        q.st == ee_pkg::EE_ACK && q.drive && !fall && !start && !stop
        |=> sda_oe)
        else $error("ack released early");
endmodule

// file: ee_pkg.sv
package ee_pkg;

    // =========================================================
    // geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int HI_W = ADDR_W - PAGE_W;
    localparam int FIFO_W = ADDR_W + DATA_W;
    localparam int FIFO_DEPTH = 4;

    // =========================================================
    // serial framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [1:0] IDX_DEV = 2'h0;
    localparam logic [1:0] IDX_AHI = 2'h1;
    localparam logic [1:0] IDX_ALO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 7'h7F;
    localparam logic [PAGE_W-1:0] PAGE_ONE = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 5000000;
    // longest time: round down
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 18;
    localparam int PROG_CYCLES = 4;

    // =========================================================
    // interface sequencer
    typedef enum logic [2:0] {
        EE_IDLE,
        EE_RX,
        EE_ACK,
        EE_TX,
        EE_MACK
    } ee_state_t;

endpackage

// file: ee_fifo.sv
module ee_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] CNT_MAX = (PW+1)'(DEPTH);
    localparam logic [PW:0] CNT_ONE = (PW+1)'(1);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } ee_fifo_t;

    ee_fifo_t q, d;
    logic push, pop;

    assign in_ready = q.cnt != CNT_MAX;
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = q.wp + PTR_ONE;
        end
        if (pop) begin
            d.rp = q.rp + PTR_ONE;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + CNT_ONE;
        end else if (pop && !push) begin
            d.cnt = q.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        q.cnt <= CNT_MAX) else $error("fifo count beyond depth");
endmodule

// file: ee_array.sv
module ee_array #(
    parameter int AW = 16,
    parameter int DW = 8,
    parameter int PROG = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [AW+DW-1:0] wr_word,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    localparam int CW = $clog2(PROG + 1);
    localparam logic [CW-1:0] PROG_LIM = CW'(PROG);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    typedef struct packed {
        logic [CW-1:0] wait_cnt;
    } ee_array_t;

    ee_array_t q, d;
    logic [DW-1:0] cells [0:(1<<AW)-1];
    logic take;

    // =========================================================
    // program pacing
    assign wr_ready = q.wait_cnt == '0;
    assign take = wr_valid & wr_ready;
    assign rd_data = cells[rd_addr];

    always_comb begin
        d = q;
        if (take) begin
            d.wait_cnt = PROG_LIM;
        end else if (q.wait_cnt != '0) begin
            d.wait_cnt = q.wait_cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // cells hold content over reset
    always_ff @(posedge clk_sys) begin
        if (take) begin
            cells[wr_word[AW+DW-1:DW]] <= wr_word[DW-1:0];
        end
    end
endmodule

// file: ee_bus_master.sv
module ee_bus_master (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // idle bus: clock and data released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic start_c();
        tick(4);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop_c();
        tick(4);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask

    task automatic xbit(input logic b, output logic r);
        tick(2);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        r = sda_line;
        tick(1);
        scl <= 1'b0;
    endtask

    // eight bits msb first, then ack slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], r);
        end
        xbit(1'b1, ack);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(nack, r);
    endtask
endmodule

// file: ee_slave_test.sv
module ee_slave_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] CODE = 4'h5; // arbitrary value
    localparam int WCYC = 200;
    logic clk_sys, rstn, scl, sda_low, sda_o, sda_oe, write_busy, wp;
    logic sda_line;
    logic [2:0] sel;
    int failures, n_tests, ptr;
    logic [7:0] mem [int];

    // open-drain wire with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    ee_slave #(.DEV_CODE(CODE), .WRITE_CYCLES(WCYC)) i_ee_slave (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]),
        .select_pin_bit2(sel[2]),
        .write_protect(wp),
        .write_busy(write_busy)
    );

    ee_bus_master u_master (
        .clk_sys(clk_sys),
        .sda_line(sda_line),
        .scl(scl),
        .sda_low(sda_low)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // =========================================================
    // compare and verdict
    task automatic chk_bit(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // =========================================================
    // transaction helpers
    task automatic hdr(input logic [3:0] c, input logic [2:0] s,
                       input logic rw, output logic ack);
        u_master.start_c();
        u_master.send_byte({c, s, rw}, ack);
    endtask

    task automatic poll(input logic prot);
        logic ack;
        logic [7:0] d;
        int k;
        @(negedge clk_sys);
        if (!prot) chk_bit(1'b1, write_busy);
        k = 0;
        ack = 1'b1;
        while (ack && k < 60) begin
            hdr(CODE, sel, 1'b1, ack);
            if (k == 0 && !prot) chk_bit(1'b1, ack);
            if (ack) u_master.stop_c();
            k++;
        end
        chk_bit(1'b0, ack);
        @(negedge clk_sys);
        chk_bit(1'b0, write_busy);
        u_master.recv_byte(1'b1, d);
        u_master.stop_c();
    endtask

    task automatic wr(input logic [15:0] a, input int n, input logic prot);
        logic ack;
        logic [7:0] d;
        hdr(CODE, sel, 1'b0, ack);
        chk_bit(1'b0, ack);
        u_master.send_byte(a[15:8], ack);
        chk_bit(1'b0, ack);
        u_master.send_byte(a[7:0], ack);
        chk_bit(1'b0, ack);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_master.send_byte(d, ack);
            chk_bit(prot, ack);
            // low seven bits roll within the page
            if (!prot) mem[{a[15:7], 7'(a[6:0] + i)}] = d;
        end
        u_master.stop_c();
        poll(prot);
    endtask

    task automatic rd(input logic [15:0] a, input int n, input logic set);
        logic ack;
        logic [7:0] d;
        if (set) begin
            hdr(CODE, sel, 1'b0, ack);
            u_master.send_byte(a[15:8], ack);
            u_master.send_byte(a[7:0], ack);
            ptr = a;
        end
        hdr(CODE, sel, 1'b1, ack);
        chk_bit(1'b0, ack);
        for (int i = 0; i < n; i++) begin
            u_master.recv_byte(i == n - 1, d);
            chk_byte(mem[ptr], d);
            ptr = (ptr + 1) % 65536;
        end
        u_master.stop_c();
    endtask

    // =========================================================
    // main sequence
    initial begin
        logic ack, r;
        logic [7:0] d;
        void'($urandom(7239));
        failures = 0;
        n_tests = 0;
        rstn = 1'b0;
        wp = 1'b0;
        sel = 3'($urandom);
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit(1'b0, sda_oe);
        chk_bit(1'b0, write_busy);
        for (int s = 0; s < 8; s++) begin
            hdr(CODE, 3'(s), 1'b1, ack);
            chk_bit(3'(s) != sel, ack);
            if (!ack) u_master.recv_byte(1'b1, d);
            u_master.stop_c();
        end
        hdr(CODE ^ 4'h8, sel, 1'b1, ack);
        chk_bit(1'b1, ack);
        u_master.stop_c();
        wr(16'h3A7E, 130, 1'b0);
        rd(16'h3A00, 124, 1'b1);
        rd(16'h0000, 4, 1'b0);
        // protect held across the whole write
        @(posedge clk_sys);
        wp <= 1'b1;
        wr(16'h3A10, 3, 1'b1);
        @(posedge clk_sys);
        wp <= 1'b0;
        rd(16'h3A10, 3, 1'b1);
        wr(16'hFFFF, 1, 1'b0);
        wr(16'h0000, 1, 1'b0);
        rd(16'hFFFF, 2, 1'b1);
        rd(16'hFFFF, 1, 1'b1);
        // start, nine released clocks, start and stop
        u_master.start_c();
        repeat (9) u_master.xbit(1'b1, r);
        u_master.start_c();
        u_master.stop_c();
        rd(16'h0000, 1, 1'b0);
        close_out();
    end

    initial begin
        #1600000;
        failures++;
        close_out();
    end
endmodule
